// ===== rtl/pin_mux_params.svh
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH
// ----------------------------------------
// reset values
// ----------------------------------------
`define PM_DIR_RST       8'h00
`define PM_DATA_RST      8'h00
// ----------------------------------------
// port three bit positions
// ----------------------------------------
`define PM_P3_WAIT_BIT   0
`define PM_P3_READ_BIT   1
`define PM_P3_BLW_BIT    2
`define PM_P3_BHW_BIT    3
// ----------------------------------------
// port four bit positions
// ----------------------------------------
`define PM_P4_ALE_BIT    0
`define PM_P4_HOLD_BIT   1
`define PM_P4_HLDA_BIT   2
`define PM_P4_CLK_BIT    3
`endif

// ===== rtl/pin_mux_pkg.sv
package pin_mux_pkg;
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'b001,
    MODE_EXPAND = 3'b010,
    MODE_MICRO  = 3'b100
  } proc_mode_e;

  // bus-side request from the internal bus interface
  typedef struct packed {
    logic [7:0] upper_address_bits;
    logic [7:0] muxed_low_address;
    logic [7:0] low_data_byte;
    logic [7:0] high_data_byte;
    logic       addr_phase;
    logic       data_out_en;
    logic       read_strobe_n;
    logic       low_byte_write_strobe_n;
    logic       high_byte_write_strobe_n;
    logic       addr_latch_strobe;
    logic [2:0] p4_ctrl_out;
    logic [2:0] p4_ctrl_oe;
  } bus_req_s;

  // per-port pin bundle, output enable low while driving
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe_n;
  } port_pins_s;
endpackage

// ===== rtl/external_bus_pin_mux.sv
// Overview of operation
// R01: mode pin high selects microprocessor mode
// R02: bus-width pin low 16-bit, high 8-bit
// R03: chip-select areas may each force 8-bit bus
// R04: single-chip port zero is 8-bit GPIO
// R05: reset clears direction so pins input
// R06: expanded port zero drives upper address, optional GPIO
// R07: expanded port one carries low data byte
// R08: 8-bit bus port one may multiplex address
// R09: 16-bit expanded port two carries high byte
// R10: expansion: bit0 GPIO, bits1-3 strobes
// R11: microprocessor: bit0 wait input, bits1-3 strobes
// R12: 8-bit bus frees high write strobe pin
// R13: expansion port four GPIO unless bus-control selected
// R14: bus function beats direction, decided combinationally
`timescale 1ns/10ps
`include "pin_mux_params.svh"
module external_bus_pin_mux (
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_processor_mode_pin,
  input  wire logic                   i_expand_en,
  input  wire logic                   i_bus_width_pin,
  input  wire logic [2:0]             i_chip_select_areas_8bit,
  input  wire logic [2:0]             i_chip_select_areas_active,
  input  wire logic [7:0]             i_p0_gpio_sel,
  input  wire logic                   i_p1_muxed_addr_en,
  input  wire logic                   i_p4_bus_ctrl_en,
  input  wire logic                   i_dir_we,
  input  wire logic [2:0]             i_dir_port_sel,
  input  wire logic [7:0]             i_dir_wdata,
  input  wire logic                   i_data_we,
  input  wire logic [7:0]             i_data_wdata,
  input  wire pin_mux_pkg::bus_req_s  i_bus,
  input  wire logic [7:0]             i_port_zero_in,
  input  wire logic [7:0]             i_port_one_in,
  input  wire logic [7:0]             i_port_two_in,
  input  wire logic [3:0]             i_port_three_in,
  input  wire logic [7:0]             i_port_four_in,
  output pin_mux_pkg::port_pins_s     o_port_zero,
  output pin_mux_pkg::port_pins_s     o_port_one,
  output pin_mux_pkg::port_pins_s     o_port_two,
  output pin_mux_pkg::port_pins_s     o_port_three,
  output pin_mux_pkg::port_pins_s     o_port_four,
  output logic [39:0]                 o_port_level,
  output logic [7:0]                  o_low_data_byte_in,
  output logic [7:0]                  o_high_data_byte_in,
  output logic                        o_wait_ready,
  output logic                        o_bus_16bit,
  output pin_mux_pkg::proc_mode_e     o_mode
);
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  pin_mux_pkg::proc_mode_e mode;
  logic                    mode_pin_s1_reg;
  logic                    mode_pin_s2_reg;
  logic                    width_s1_reg;
  logic                    width_s2_reg;
  logic                    expanded;
  logic                    narrow;

  // the mode pin is a level from the board, so it is only ever read after the synchroniser

  always_comb begin
    if (mode_pin_s2_reg) begin
      mode = pin_mux_pkg::MODE_MICRO;                              // see R01
    end else if (i_expand_en) begin
      mode = pin_mux_pkg::MODE_EXPAND;
    end else begin
      mode = pin_mux_pkg::MODE_SINGLE;
    end
  end
  assign expanded = (mode != pin_mux_pkg::MODE_SINGLE);
  // narrow if pin high, or an active area asks for 8-bit on its own
  assign narrow = width_s2_reg |                                   // see R02
                  (|(i_chip_select_areas_8bit & i_chip_select_areas_active)); // see R03

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // mode and width pins share the same two-stage treatment as the port pins
  logic [39:0] pin_raw;
  logic [39:0] pin_s1_reg;
  logic [39:0] pin_s2_reg;
  assign pin_raw = {i_port_four_in, 4'h0, i_port_three_in, i_port_two_in, i_port_one_in, i_port_zero_in};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_reg      <= 40'h00_0000_0000;
      pin_s2_reg      <= 40'h00_0000_0000;
      mode_pin_s1_reg <= 1'b0;
      mode_pin_s2_reg <= 1'b0;
      width_s1_reg    <= 1'b0;
      width_s2_reg    <= 1'b0;
    end else begin
      pin_s1_reg      <= pin_raw;
      pin_s2_reg      <= pin_s1_reg;
      mode_pin_s1_reg <= i_processor_mode_pin;
      mode_pin_s2_reg <= mode_pin_s1_reg;
      width_s1_reg    <= i_bus_width_pin;
      width_s2_reg    <= width_s1_reg;
    end
  end

  // ----------------------------------------
  // direction and data latches
  // ----------------------------------------
  logic [7:0] dir_reg [5];
  logic [7:0] dir_next [5];
  logic [7:0] data_reg [5];
  logic [7:0] data_next [5];

  // a port select above four matches no latch, so that write is dropped
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_port
      always_comb begin
        dir_next[g]  = dir_reg[g];
        data_next[g] = data_reg[g];
        if (i_dir_we && (i_dir_port_sel == 3'(g))) begin
          dir_next[g] = i_dir_wdata;
        end
        if (i_data_we && (i_dir_port_sel == 3'(g))) begin
          data_next[g] = i_data_wdata;
        end
      end
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          dir_reg[g]  <= `PM_DIR_RST;                                // see R05
          data_reg[g] <= `PM_DATA_RST;
        end else begin
          dir_reg[g]  <= dir_next[g];
          data_reg[g] <= data_next[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // pin ownership
  // ----------------------------------------
  // bus ownership is pure logic so a mode change takes effect at once
  function automatic pin_mux_pkg::port_pins_s mix(
    input logic [7:0] bus_own,
    input logic [7:0] bus_o,
    input logic [7:0] bus_drv,
    input logic [7:0] dat,
    input logic [7:0] dir
  );
    pin_mux_pkg::port_pins_s r;
    r.o    = (bus_own & bus_o) | (~bus_own & dat);
    r.oe_n = ~((bus_own & bus_drv) | (~bus_own & dir));            // see R14
    return r;
  endfunction

  logic [7:0] p0_own;
  logic [7:0] p1_own;
  logic [7:0] p2_own;
  logic [7:0] p3_own;
  logic [7:0] p4_own;
  logic [7:0] p1_o;
  logic [7:0] p3_o;
  logic [7:0] p3_drv;
  logic [7:0] p4_o;
  logic [7:0] p4_drv;
  logic       wide_data;
  logic       addr_drive;

  assign wide_data = expanded & ~narrow;

  // ----------------------------------------
  // port zero and port one
  // ----------------------------------------
  // a pin handed back to general I/O keeps its own latch and direction
  assign p0_own    = expanded ? ~i_p0_gpio_sel : 8'h00;             // see R06
  assign p1_own    = expanded ? 8'hFF : 8'h00;                      // see R07
  // the address goes out only in the address phase; the data phase keeps the bus direction
  assign addr_drive = narrow & i_p1_muxed_addr_en & i_bus.addr_phase;
  assign p1_o      = addr_drive ? i_bus.muxed_low_address : i_bus.low_data_byte; // see R08

  // ----------------------------------------
  // port two and port three
  // ----------------------------------------
  assign p2_own    = wide_data ? 8'hFF : 8'h00;                     // see R09
  // wait input is sampled by the pin synchroniser; pin itself left undriven
  assign p3_own    = expanded ? {4'h0, ~narrow, 2'b11,
                                 (mode == pin_mux_pkg::MODE_MICRO)} : 8'h00; // see R10 see R11 see R12
  assign p3_o      = {4'h0, i_bus.high_byte_write_strobe_n, i_bus.low_byte_write_strobe_n,
                      i_bus.read_strobe_n, 1'b0};
  // only the three strobes are ever driven from the bus side
  assign p3_drv    = 8'h0E;

  // ----------------------------------------
  // port four
  // ----------------------------------------
  // limitation: bits 7:4 stay general I/O even with bus control selected
  assign p4_own    = (expanded && i_p4_bus_ctrl_en) ? 8'h0F : 8'h00; // see R13
  assign p4_o      = {4'h0, i_bus.p4_ctrl_out, i_bus.addr_latch_strobe};
  assign p4_drv    = {4'h0, i_bus.p4_ctrl_oe, 1'b1};

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  always_comb begin
    o_port_zero  = mix(p0_own, i_bus.upper_address_bits, 8'hFF, data_reg[0], dir_reg[0]); // see R04
    o_port_one   = mix(p1_own, p1_o, {8{i_bus.data_out_en | addr_drive}}, data_reg[1], dir_reg[1]);
    o_port_two   = mix(p2_own, i_bus.high_data_byte, {8{i_bus.data_out_en}}, data_reg[2], dir_reg[2]);
    o_port_three = mix(p3_own, p3_o, p3_drv, data_reg[3] & 8'h0F, dir_reg[3] & 8'h0F);
    o_port_four  = mix(p4_own, p4_o, p4_drv, data_reg[4], dir_reg[4]);
  end

  // ----------------------------------------
  // synchronised inputs
  // ----------------------------------------
  // the high byte reads zero on a narrow bus so stale port two levels never leak in
  assign o_port_level        = pin_s2_reg;
  assign o_low_data_byte_in  = pin_s2_reg[15:8];
  assign o_high_data_byte_in = wide_data ? pin_s2_reg[23:16] : 8'h00;
  assign o_wait_ready        = (mode == pin_mux_pkg::MODE_MICRO) ? pin_s2_reg[24 + `PM_P3_WAIT_BIT] : 1'b1; // see R11
  assign o_bus_16bit         = wide_data;
  assign o_mode              = mode;
endmodule

// ===== bench/ext_bus_partner.sv
`timescale 1ns/10ps
module ext_bus_partner (
  input  wire logic                    i_clk,
  input  wire pin_mux_pkg::port_pins_s i_strobe,
  input  wire logic [7:0]              i_addr,
  input  wire logic                    i_slow,
  output logic [15:0]                  o_data,
  output logic                         o_ready
);
  // ----
  // memory answer
  // ----
  initial o_data = 16'h5AA5;
  always @(posedge i_clk) begin
    if (!i_strobe.o[1] && !i_strobe.oe_n[1]) begin
      o_data <= {~i_addr, i_addr};
    end else begin
      o_data <= ~o_data; // released bus toggles so stale bytes never look valid
    end
    o_ready <= !i_slow;
  end
endmodule

// ===== bench/external_bus_pin_mux_properties.sv
`timescale 1ns/10ps
module external_bus_pin_mux_properties (
  input wire logic                    i_clk,
  input wire logic                    i_arst_n,
  input wire logic                    i_processor_mode_pin,
  input wire logic [2:0]              i_chip_select_areas_8bit,
  input wire logic [2:0]              i_chip_select_areas_active,
  input wire logic [7:0]              i_p0_gpio_sel,
  input wire logic                    i_p1_muxed_addr_en,
  input wire logic                    i_dir_we,
  input wire logic [2:0]              i_dir_port_sel,
  input wire logic [7:0]              i_dir_wdata,
  input wire pin_mux_pkg::bus_req_s   i_bus,
  input wire pin_mux_pkg::port_pins_s o_port_zero,
  input wire pin_mux_pkg::port_pins_s o_port_one,
  input wire pin_mux_pkg::port_pins_s o_port_three,
  input wire logic                    o_bus_16bit,
  input wire pin_mux_pkg::proc_mode_e o_mode
);
  // ----
  // mode, bus width and pin ownership
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic ext = !o_mode[0];
  sequence s_dir_wr;
    o_mode[0] && i_dir_we && i_dir_port_sel == 3'h0;
  endsequence
  a_mode_micro: assert property (i_processor_mode_pin [*3] |-> o_mode == pin_mux_pkg::MODE_MICRO)
    else $error("mode not micro");
  a_cs_narrow: assert property (|(i_chip_select_areas_8bit & i_chip_select_areas_active) |-> !o_bus_16bit)
    else $error("area not narrow");
  a_dir_apply: assert property (s_dir_wr ##1 o_mode[0] |-> o_port_zero.oe_n == ~$past(i_dir_wdata))
    else $error("direction lost");
  a_reset_input: assert property ($rose(i_arst_n) && o_mode[0] |-> o_port_zero.oe_n == 8'hFF)
    else $error("pins not input");
  a_upper_addr: assert property (ext && i_p0_gpio_sel == 8'h00 |-> o_port_zero.oe_n == 8'h00
    && o_port_zero.o == i_bus.upper_address_bits) else $error("upper address");
  a_addr_mux: assert property (ext && !o_bus_16bit && i_p1_muxed_addr_en && i_bus.addr_phase
    |-> o_port_one.o == i_bus.muxed_low_address && o_port_one.oe_n == 8'h00) else $error("muxed address");
  a_bus_strobes: assert property (ext |-> o_port_three.oe_n[2:1] == 2'h0
    && o_port_three.o[2:1] == {i_bus.low_byte_write_strobe_n, i_bus.read_strobe_n}) else $error("strobes");
  a_wait_input: assert property (o_mode[2] |-> o_port_three.oe_n[0])
    else $error("wait pin driven");
endmodule
bind external_bus_pin_mux external_bus_pin_mux_properties external_bus_pin_mux_properties_i (.*);

// ===== bench/tb_external_bus_pin_mux.sv
`timescale 1ns/10ps
module tb_external_bus_pin_mux;
  logic                    i_clk = 1'h0, i_arst_n = 1'h0, i_processor_mode_pin = 1'h0, i_expand_en = 1'h0;
  logic                    i_bus_width_pin = 1'h0, i_p1_muxed_addr_en = 1'h1, i_p4_bus_ctrl_en = 1'h0, slow = 1'h0;
  logic                    i_dir_we = 1'h0, i_data_we = 1'h0, ready, o_wait_ready, o_bus_16bit;
  logic [2:0]              i_chip_select_areas_8bit = 3'h0, i_chip_select_areas_active = 3'h0, i_dir_port_sel = 3'h0;
  logic [7:0]              i_p0_gpio_sel = 8'h00, i_dir_wdata = 8'h00, i_data_wdata = 8'h00, i_port_zero_in = 8'h00;
  logic [7:0]              i_port_four_in = 8'h00, o_low_data_byte_in, o_high_data_byte_in;
  logic [15:0]             mem_d;
  logic [31:0]             seed = 32'h91842FAC;
  logic [39:0]             o_port_level;
  int                      mismatches = 0, cmp_count = 0;
  pin_mux_pkg::bus_req_s   i_bus = '0;
  pin_mux_pkg::port_pins_s o_port_zero, o_port_one, o_port_two, o_port_three, o_port_four;
  pin_mux_pkg::proc_mode_e o_mode;
  wire logic [7:0]         i_port_one_in = mem_d[7:0];
  wire logic [7:0]         i_port_two_in = mem_d[15:8];
  wire logic [3:0]         i_port_three_in = {seed[3:1], ready};
  external_bus_pin_mux external_bus_pin_mux_i (.*);
  ext_bus_partner ext_bus_partner_i (.i_clk, .i_strobe(o_port_three), .i_addr(o_port_one.o), .i_slow(slow),
    .o_data(mem_d), .o_ready(ready));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] dir_oe(input logic [7:0] d);
    return ~d;
  endfunction
  function automatic logic wide(input logic pin, input logic [5:0] cs);
    return !pin && !(|(cs[5:3] & cs[2:0]));
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #4 i_clk = ~i_clk;
  initial begin
    pin_mux_pkg::port_pins_s p;
    repeat (20) @(negedge i_clk);
    i_arst_n = 1'h1;
    @(negedge i_clk);
    chk(o_port_zero.oe_n, 16'h00FF);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      {i_dir_we, i_data_we, i_dir_port_sel} = {2'h3, 2'h0, k[0]};
      i_dir_wdata = (k == 7) ? 8'hFF : seed[7:0];
      i_data_wdata = seed[15:8];
      @(negedge i_clk);
      p = k[0] ? o_port_one : o_port_zero;
      chk(p.oe_n, dir_oe(i_dir_wdata));
      chk(p.o | p.oe_n, i_data_wdata | dir_oe(i_dir_wdata));
    end
    {i_dir_we, i_data_we, i_expand_en} = 3'h1;
    $display("single-chip test done");
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      i_bus = {seed, seed[11:0]};
      {i_bus_width_pin, i_processor_mode_pin, slow, i_p4_bus_ctrl_en} = {k[1], k[2], seed[5:4]};
      {i_chip_select_areas_8bit, i_chip_select_areas_active} = k[0] ? seed[21:16] : 6'h00;
      i_p0_gpio_sel = k[0] ? seed[31:24] : 8'h00;
      {i_port_zero_in, i_port_four_in} = seed[31:16];
      repeat (3) @(negedge i_clk);
      chk(o_mode, k[2] ? pin_mux_pkg::MODE_MICRO : pin_mux_pkg::MODE_EXPAND);
      chk(o_bus_16bit, wide(k[1], {i_chip_select_areas_8bit, i_chip_select_areas_active}));
      chk(o_port_zero.o & ~i_p0_gpio_sel, i_bus.upper_address_bits & ~i_p0_gpio_sel);
      chk(o_port_zero.oe_n & ~i_p0_gpio_sel, 16'h0000);
      chk(o_port_level[7:0], i_port_zero_in);
      chk(o_port_level[39:32], i_port_four_in);
      if (!o_bus_16bit) chk(o_high_data_byte_in, 16'h0000);
      chk(o_port_three.o[2:1], {i_bus.low_byte_write_strobe_n, i_bus.read_strobe_n});
      chk(o_wait_ready, k[2] ? !slow : 1'h1);
      if (o_bus_16bit === 1'h1 && i_bus.data_out_en) chk(o_port_two.o, i_bus.high_data_byte);
      if (!k[0]) chk(o_port_three.oe_n[3], k[1]);
      if (k[1] && i_bus.addr_phase) chk(o_port_one.o, i_bus.muxed_low_address);
      if (!k[2] && i_p4_bus_ctrl_en) chk(o_port_four.o[0], i_bus.addr_latch_strobe);
      if (i_p4_bus_ctrl_en) chk(o_port_four.oe_n[0], 16'h0000);
    end
    $display("expanded bus test done");
    summarize();
  end
endmodule
